// >>> matd_pkg.sv
// Package with register map, field layout and event constants for motion detection
package matd_pkg;

    // Register offsets (byte addresses on the 8-bit register port)
    localparam logic [7:0] MATD_ADDR_ACT_THR_UP = 8'h20;
    localparam logic [7:0] MATD_ADDR_ACT_THR_LO = 8'h21;
    localparam logic [7:0] MATD_ADDR_ACT_PCNT = 8'h22;
    localparam logic [7:0] MATD_ADDR_INACT_THR_UP = 8'h23;
    localparam logic [7:0] MATD_ADDR_INACT_THR_LO = 8'h24;
    localparam logic [7:0] MATD_ADDR_INACT_PCNT_UP = 8'h25;
    localparam logic [7:0] MATD_ADDR_INACT_PCNT_LO = 8'h26;
    localparam logic [7:0] MATD_ADDR_EVT_STATUS = 8'h30;
    localparam logic [7:0] MATD_ADDR_EVT_MASK = 8'h31;

    // Field layout
    localparam int MATD_DATA_W = 14;
    localparam int MATD_THR_W = 13;
    localparam int MATD_THR_UP_W = 7;
    localparam int MATD_THR_LO_W = 6;
    localparam int MATD_THR_LO_POS = 2;
    localparam int MATD_ACT_CNT_W = 8;
    localparam int MATD_INACT_CNT_W = 16;

    // Reset values
    localparam logic [7:0] MATD_REG_RESET = 8'h00;

    // Event bit positions in status and mask
    localparam int MATD_EVT_ACT = 0;
    localparam int MATD_EVT_INACT = 1;
    localparam int MATD_EVT_W = 2;

endpackage : matd_pkg

// >>> matd_axis_cmp.sv
// Per-axis magnitude compare against activity and inactivity thresholds
`timescale 1ns/1ps
module matd_axis_cmp
(
    input wire logic signed [matd_pkg::MATD_DATA_W-1:0] sample_i,
    input wire logic [matd_pkg::MATD_THR_W-1:0] act_thr_i,
    input wire logic [matd_pkg::MATD_THR_W-1:0] inact_thr_i,
    output logic above_act_o,
    output logic below_inact_o
);
    import matd_pkg::*;

    logic [MATD_DATA_W-1:0] mag;

    // Magnitude in 14 bits so that the most negative code stays exact
    always_comb
    begin
        if (sample_i[MATD_DATA_W-1])
            mag = MATD_DATA_W'(-sample_i);
        else
            mag = MATD_DATA_W'(sample_i);
    end

    // Threshold is in raw codes, compared strictly against the magnitude
    assign above_act_o = mag > {1'b0, act_thr_i};
    assign below_inact_o = mag < {1'b0, inact_thr_i};

endmodule : matd_axis_cmp

// >>> matd_detect.sv
// Activity and inactivity detection with register file and interrupt
`timescale 1ns/1ps
module matd_detect
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic sample_valid_i,
    input wire logic signed [matd_pkg::MATD_DATA_W-1:0] x_data_i,
    input wire logic signed [matd_pkg::MATD_DATA_W-1:0] y_data_i,
    input wire logic signed [matd_pkg::MATD_DATA_W-1:0] z_data_i,
    output logic act_event_o,
    output logic inact_event_o,
    output logic irq_o
);
    import matd_pkg::*;

    logic [MATD_THR_UP_W-1:0] act_thr_up_q;
    logic [MATD_THR_LO_W-1:0] act_thr_lo_q;
    logic [MATD_ACT_CNT_W-1:0] act_pcnt_q;
    logic [MATD_THR_UP_W-1:0] inact_thr_up_q;
    logic [MATD_THR_LO_W-1:0] inact_thr_lo_q;
    logic [MATD_INACT_CNT_W-1:0] inact_pcnt_q;
    logic [MATD_EVT_W-1:0] evt_status_q;
    logic [MATD_EVT_W-1:0] evt_mask_q;
    logic [MATD_ACT_CNT_W-1:0] act_run_q;
    logic [MATD_INACT_CNT_W-1:0] inact_run_q;
    logic act_event_q;
    logic inact_event_q;
    logic [7:0] rdata_q;
    logic [MATD_THR_W-1:0] act_thr;
    logic [MATD_THR_W-1:0] inact_thr;
    logic [2:0] above;
    logic [2:0] below;
    logic any_above;
    logic all_below;
    logic act_hit;
    logic inact_hit;
    logic [MATD_EVT_W-1:0] evt_set;

    // Compose the 13-bit thresholds from their register halves
    assign act_thr = {act_thr_up_q, act_thr_lo_q};
    assign inact_thr = {inact_thr_up_q, inact_thr_lo_q};

    // Same compare reused for each axis, no cross-axis coupling
    matd_axis_cmp u_cmp_x
    (
        .sample_i(x_data_i),
        .act_thr_i(act_thr),
        .inact_thr_i(inact_thr),
        .above_act_o(above[0]),
        .below_inact_o(below[0])
    );

    matd_axis_cmp u_cmp_y
    (
        .sample_i(y_data_i),
        .act_thr_i(act_thr),
        .inact_thr_i(inact_thr),
        .above_act_o(above[1]),
        .below_inact_o(below[1])
    );

    matd_axis_cmp u_cmp_z
    (
        .sample_i(z_data_i),
        .act_thr_i(act_thr),
        .inact_thr_i(inact_thr),
        .above_act_o(above[2]),
        .below_inact_o(below[2])
    );

    assign any_above = |above;
    assign all_below = &below;

    // Count reached: a programmed count of zero behaves as one sample
    function automatic logic cnt_done(input logic [15:0] run, input logic [15:0] limit);
        cnt_done = (run + 16'h0001) >= limit;
    endfunction : cnt_done

    assign act_hit = sample_valid_i && any_above
        && cnt_done(16'(act_run_q), 16'(act_pcnt_q));
    assign inact_hit = sample_valid_i && all_below
        && cnt_done(inact_run_q, inact_pcnt_q);
    assign evt_set = {inact_hit, act_hit};

    // Register writes; reserved bits are simply not stored
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            act_thr_up_q <= '0;
            act_thr_lo_q <= '0;
            act_pcnt_q <= MATD_REG_RESET;
            inact_thr_up_q <= '0;
            inact_thr_lo_q <= '0;
            inact_pcnt_q <= '0;
            evt_mask_q <= '0;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                MATD_ADDR_ACT_THR_UP: act_thr_up_q <= reg_wdata_i[MATD_THR_UP_W-1:0];
                MATD_ADDR_ACT_THR_LO: act_thr_lo_q <= reg_wdata_i[7:MATD_THR_LO_POS];
                MATD_ADDR_ACT_PCNT: act_pcnt_q <= reg_wdata_i;
                MATD_ADDR_INACT_THR_UP: inact_thr_up_q <= reg_wdata_i[MATD_THR_UP_W-1:0];
                MATD_ADDR_INACT_THR_LO: inact_thr_lo_q <= reg_wdata_i[7:MATD_THR_LO_POS];
                MATD_ADDR_INACT_PCNT_UP: inact_pcnt_q[15:8] <= reg_wdata_i;
                MATD_ADDR_INACT_PCNT_LO: inact_pcnt_q[7:0] <= reg_wdata_i;
                MATD_ADDR_EVT_MASK: evt_mask_q <= reg_wdata_i[MATD_EVT_W-1:0];
                default: ;
            endcase
        end
    end

    // Read data one cycle after the strobe; unmapped and reserved read zero
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_q <= 8'h00;
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                MATD_ADDR_ACT_THR_UP: rdata_q <= {1'b0, act_thr_up_q};
                MATD_ADDR_ACT_THR_LO: rdata_q <= {act_thr_lo_q, 2'b00};
                MATD_ADDR_ACT_PCNT: rdata_q <= act_pcnt_q;
                MATD_ADDR_INACT_THR_UP: rdata_q <= {1'b0, inact_thr_up_q};
                MATD_ADDR_INACT_THR_LO: rdata_q <= {inact_thr_lo_q, 2'b00};
                MATD_ADDR_INACT_PCNT_UP: rdata_q <= inact_pcnt_q[15:8];
                MATD_ADDR_INACT_PCNT_LO: rdata_q <= inact_pcnt_q[7:0];
                MATD_ADDR_EVT_STATUS: rdata_q <= {6'h00, evt_status_q};
                MATD_ADDR_EVT_MASK: rdata_q <= {6'h00, evt_mask_q};
                default: rdata_q <= 8'h00;
            endcase
        end
        else
            rdata_q <= 8'h00;
    end

    assign reg_rdata_o = rdata_q;

    // Run lengths of consecutive qualifying samples, restart on a miss
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            act_run_q <= '0;
        else if (sample_valid_i)
        begin
            if (!any_above || act_hit)
                act_run_q <= '0;
            else
                act_run_q <= act_run_q + 8'h01;
        end
    end

    // Inactivity run is 16 bits wide to cover long quiet periods
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            inact_run_q <= '0;
        else if (sample_valid_i)
        begin
            if (!all_below || inact_hit)
                inact_run_q <= '0;
            else
                inact_run_q <= inact_run_q + 16'h0001;
        end
    end

    // One-cycle event pulses, registered for clean outputs
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            act_event_q <= 1'b0;
            inact_event_q <= 1'b0;
        end
        else
        begin
            act_event_q <= act_hit;
            inact_event_q <= inact_hit;
        end
    end

    assign act_event_o = act_event_q;
    assign inact_event_o = inact_event_q;

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            evt_status_q <= '0;
        else if (reg_wr_i && reg_addr_i == MATD_ADDR_EVT_STATUS)
            evt_status_q <= (evt_status_q & ~reg_wdata_i[MATD_EVT_W-1:0]) | evt_set;
        else
            evt_status_q <= evt_status_q | evt_set;
    end

    assign irq_o = |(evt_status_q & evt_mask_q);

    // Checks
    a_act_pulse_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        act_event_o |-> $past(sample_valid_i) && $past(any_above))
        else $error("activity event without an above-threshold sample");
    a_inact_pulse_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        inact_event_o |-> $past(sample_valid_i) && $past(all_below))
        else $error("inactivity event without an all-below sample");
    a_act_run_reset: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        sample_valid_i && !any_above |=> act_run_q == 8'h00)
        else $error("activity run not restarted");
    a_act_count_min: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        act_hit |-> 16'(act_run_q) + 16'h0001 >= 16'(act_pcnt_q))
        else $error("activity declared too early");
    a_inact_count_min: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        inact_hit |-> inact_run_q + 16'h0001 >= inact_pcnt_q)
        else $error("inactivity declared too early");
    a_act_thr_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == MATD_ADDR_ACT_THR_LO |=> reg_rdata_o[1:0] == 2'b00
        && reg_rdata_o[7:2] == act_thr[5:0])
        else $error("activity threshold lower readback wrong");
    a_inact_up_rsvd: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == MATD_ADDR_INACT_THR_UP |=> !reg_rdata_o[7]
        && reg_rdata_o[6:0] == inact_thr[12:6])
        else $error("inactivity upper readback wrong");
    a_inact_lo_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == MATD_ADDR_INACT_THR_LO |=>
        inact_thr[5:0] == $past(reg_wdata_i[7:2]))
        else $error("inactivity lower write lost");
    a_rsvd_act_up: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == MATD_ADDR_ACT_THR_UP |=> !reg_rdata_o[7])
        else $error("reserved bit read nonzero");
    a_status_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        act_hit |=> evt_status_q[MATD_EVT_ACT])
        else $error("activity status not set");
    a_status_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        evt_status_q[MATD_EVT_ACT]
        && !(reg_wr_i && reg_addr_i == MATD_ADDR_EVT_STATUS && reg_wdata_i[MATD_EVT_ACT])
        |=> evt_status_q[MATD_EVT_ACT])
        else $error("activity status dropped without a clear");

    // Reference magnitude for the checks, kept apart from the axis compare
    function automatic logic [MATD_DATA_W-1:0] axis_mag(
        input logic signed [MATD_DATA_W-1:0] v);
        axis_mag = v[MATD_DATA_W-1] ? MATD_DATA_W'(-v) : MATD_DATA_W'(v);
    endfunction : axis_mag

    // Per-axis compare results against an independent reference
    a_axis_above: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        above == {axis_mag(z_data_i) > {1'b0, act_thr},
        axis_mag(y_data_i) > {1'b0, act_thr},
        axis_mag(x_data_i) > {1'b0, act_thr}})
        else $error("axis above-threshold flag wrong");

    a_axis_below: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        below == {axis_mag(z_data_i) < {1'b0, inact_thr},
        axis_mag(y_data_i) < {1'b0, inact_thr},
        axis_mag(x_data_i) < {1'b0, inact_thr}})
        else $error("axis below-threshold flag wrong");

    // A loud sample breaks the quiet run
    a_inact_run_reset: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        sample_valid_i && !all_below
        |=> inact_run_q == 16'h0000)
        else $error("inactivity run not restarted");

    // Writes land in the right threshold and count fields
    a_act_up_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == MATD_ADDR_ACT_THR_UP
        |=> act_thr[12:6] == $past(reg_wdata_i[6:0]))
        else $error("activity upper write lost");

    a_act_lo_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == MATD_ADDR_ACT_THR_LO
        |=> act_thr[5:0] == $past(reg_wdata_i[7:2]))
        else $error("activity lower write lost");

    a_inact_up_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == MATD_ADDR_INACT_THR_UP
        |=> inact_thr[12:6] == $past(reg_wdata_i[6:0]))
        else $error("inactivity upper write lost");

    a_act_cnt_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == MATD_ADDR_ACT_PCNT
        |=> act_pcnt_q == $past(reg_wdata_i))
        else $error("activity count write lost");

    a_inact_cnt_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == MATD_ADDR_INACT_PCNT_UP
        |=> inact_pcnt_q[15:8] == $past(reg_wdata_i))
        else $error("inactivity count upper write lost");

    // Read path: fields in place, zero outside the answer cycle
    a_inact_lo_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == MATD_ADDR_INACT_THR_LO
        |=> reg_rdata_o == {inact_thr[5:0], 2'b00})
        else $error("inactivity lower readback wrong");

    a_idle_rdata_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !reg_rd_i
        |=> reg_rdata_o == 8'h00)
        else $error("read data not zero outside a read");

    // A new event must survive a clear written in the same cycle
    a_set_beats_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        inact_hit && reg_wr_i && reg_addr_i == MATD_ADDR_EVT_STATUS
        |=> evt_status_q[MATD_EVT_INACT])
        else $error("inactivity status lost to a clear");

    c_act_event: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) act_event_o);
    c_inact_event: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) inact_event_o);
    c_irq: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $rose(irq_o));
    c_act_long_count: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        act_event_o && act_pcnt_q > 8'h01);
    c_clear_race: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == MATD_ADDR_EVT_STATUS && |evt_set);

endmodule : matd_detect

// >>> motion_activity_threshold_detect_tb_top.sv
// Self-checking testbench for activity and inactivity detection
`timescale 1ns/1ps
module motion_activity_threshold_detect_tb_top;
    import matd_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic sample_valid_i = 1'b0;
    logic signed [MATD_DATA_W-1:0] x_data_i = '0, y_data_i = '0, z_data_i = '0;
    logic [7:0] reg_rdata_o;
    logic act_event_o, inact_event_o, irq_o;
    int mismatches = 0;
    int num_checks = 0;
    logic [31:0] seed_q = 32'h05f9;
    int act_thr, act_n, inact_thr, inact_n, act_run, inact_run;
    logic [7:0] rd;

    // Clock at 10 MHz
    always #50 ref_clk_i = ~ref_clk_i;

    matd_detect dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .sample_valid_i(sample_valid_i), .x_data_i(x_data_i),
        .y_data_i(y_data_i), .z_data_i(z_data_i), .act_event_o(act_event_o),
        .inact_event_o(inact_event_o), .irq_o(irq_o));

    // Xorshift source, fixed seed so every run repeats
    function automatic logic [31:0] next_rand();
        seed_q = seed_q ^ (seed_q << 13);
        seed_q = seed_q ^ (seed_q >> 17);
        seed_q = seed_q ^ (seed_q << 5);
        return seed_q;
    endfunction : next_rand

    // Magnitude as int, so -8192 does not wrap
    function automatic int mag(logic signed [MATD_DATA_W-1:0] v);
        return (v < 0) ? -int'(v) : int'(v);
    endfunction : mag

    // Loud samples sit around the given level, quiet ones spread from zero up to it
    function automatic logic signed [MATD_DATA_W-1:0] pick(int base, bit quiet);
        int v;
        logic [31:0] r;
        r = next_rand();
        v = quiet ? int'(r[15:0]) % (base + 1) : base + int'(r[7:0] % 5) - 2;
        if (v < 0) v = 0;
        if (v > 8191) v = 8191;
        return MATD_DATA_W'(r[31] ? -v : v);
    endfunction : pick

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    // Reset held five cycles; also clears the bench's run counters
    task automatic do_reset();
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        act_run = 0;
        inact_run = 0;
    endtask : do_reset

    task automatic reg_write(logic [7:0] addr, logic [7:0] data);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= addr;
        reg_wdata_i <= data;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask : reg_write

    // Read data stands only in the cycle after the strobe
    task automatic reg_read(logic [7:0] addr, output logic [7:0] data);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= addr;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge ref_clk_i);
        data = reg_rdata_o;
    endtask : reg_read

    // Reserved bits written as ones to show they are ignored
    task automatic cfg(int at, int an, int it, int inn);
        act_thr = at;
        act_n = an;
        inact_thr = it;
        inact_n = inn;
        reg_write(MATD_ADDR_ACT_THR_UP, {1'b1, 7'(at >> 6)});
        reg_write(MATD_ADDR_ACT_THR_LO, {6'(at), 2'b11});
        reg_write(MATD_ADDR_ACT_PCNT, 8'(an));
        reg_write(MATD_ADDR_INACT_THR_UP, {1'b1, 7'(it >> 6)});
        reg_write(MATD_ADDR_INACT_THR_LO, {6'(it), 2'b11});
        reg_write(MATD_ADDR_INACT_PCNT_UP, 8'(inn >> 8));
        reg_write(MATD_ADDR_INACT_PCNT_LO, 8'(inn));
    endtask : cfg

    // Drives one sample and checks both event pulses against the reference
    task automatic send(logic signed [MATD_DATA_W-1:0] x, y, z);
        bit hit_a, hit_i, exp_a, exp_i;
        hit_a = mag(x) > act_thr || mag(y) > act_thr || mag(z) > act_thr;
        hit_i = mag(x) < inact_thr && mag(y) < inact_thr && mag(z) < inact_thr;
        act_run = hit_a ? act_run + 1 : 0;
        inact_run = hit_i ? inact_run + 1 : 0;
        exp_a = act_run >= ((act_n == 0) ? 1 : act_n);
        exp_i = inact_run >= ((inact_n == 0) ? 1 : inact_n);
        if (exp_a) act_run = 0;
        if (exp_i) inact_run = 0;
        @(posedge ref_clk_i);
        sample_valid_i <= 1'b1;
        x_data_i <= x;
        y_data_i <= y;
        z_data_i <= z;
        @(posedge ref_clk_i);
        sample_valid_i <= 1'b0;
        @(negedge ref_clk_i);
        check("activity event", 16'(act_event_o), 16'(exp_a));
        check("inactivity event", 16'(inact_event_o), 16'(exp_i));
    endtask : send

    task automatic chk_irq(logic exp_irq, logic [7:0] exp_st);
        @(negedge ref_clk_i);
        check("interrupt", 16'(irq_o), 16'(exp_irq));
        reg_read(MATD_ADDR_EVT_STATUS, rd);
        check("status", 16'(rd), 16'(exp_st));
    endtask : chk_irq

    // Watchdog sized well above the expected run length
    initial
    begin
        repeat (30000) @(posedge ref_clk_i);
        mismatches++;
        report_and_stop();
    end

    // Main sequence
    initial
    begin
        logic [7:0] addrs[9] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h30, 8'h31};
        logic [7:0] masks[9] = '{8'h7f, 8'hfc, 8'hff, 8'h7f, 8'hfc, 8'hff, 8'hff, 8'h00, 8'h03};
        int at_tab[4] = '{100, 8191, 0, 0};
        int an_tab[4] = '{0, 1, 3, 2};
        int it_tab[4] = '{50, 8191, 1, 0};
        int inn_tab[4] = '{1, 258, 0, 5};
        do_reset();
        foreach (addrs[i])
        begin
            reg_read(addrs[i], rd);
            check("reset value", 16'(rd), 16'h0000);
            if (addrs[i] != MATD_ADDR_EVT_STATUS) reg_write(addrs[i], 8'hff);
            reg_read(addrs[i], rd);
            check("register readback", 16'(rd), 16'(masks[i]));
        end
        reg_write(8'h40, 8'hff);
        reg_read(8'h40, rd);
        check("unmapped read", 16'(rd), 16'h0000);
        $display("test registers done");
        at_tab[3] = int'(next_rand() % 8191);
        it_tab[3] = int'(next_rand() % 200) + 10;
        foreach (at_tab[c])
        begin
            do_reset();
            cfg(at_tab[c], an_tab[c], it_tab[c], inn_tab[c]);
            if (c == 1) send(-14'sd8192, 14'sd0, 14'sd0);
            if (c == 0) send(14'sd100, -14'sd100, 14'sd101);
            repeat (150) send(pick(act_thr, 0), pick(act_thr, 0), pick(act_thr, 0));
            repeat (300) send(pick(inact_thr, 1), pick(inact_thr, 1), pick(inact_thr, 1));
            $display("test detection config %0d done", c);
        end
        do_reset();
        cfg(100, 1, 50, 1);
        reg_write(MATD_ADDR_EVT_MASK, 8'h03);
        send(14'sd200, 14'sd0, 14'sd0);
        chk_irq(1'b1, 8'h01);
        send(14'sd0, 14'sd0, 14'sd0);
        chk_irq(1'b1, 8'h03);
        reg_write(MATD_ADDR_EVT_STATUS, 8'h01);
        chk_irq(1'b1, 8'h02);
        reg_write(MATD_ADDR_EVT_STATUS, 8'h02);
        chk_irq(1'b0, 8'h00);
        reg_write(MATD_ADDR_EVT_MASK, 8'h00);
        send(14'sd0, -14'sd49, 14'sd0);
        chk_irq(1'b0, 8'h02);
        reg_write(MATD_ADDR_EVT_MASK, 8'h02);
        chk_irq(1'b1, 8'h02);
        $display("test interrupt done");
        report_and_stop();
    end
endmodule : motion_activity_threshold_detect_tb_top
